// ==== logic/gpb_pin_ctrl.sv ====
`timescale 1ns/1ps

// Pad control decode for one port; purely combinational
module gpb_pin_ctrl #(
    parameter int   W       = 8,
    parameter logic TRUE_OD = 1'b0
) (
    input  wire logic [W-1:0] val_in,
    input  wire logic [W-1:0] dir_in,
    input  wire logic [W-1:0] opt_in,
    input  wire logic [W-1:0] alt_en_in,
    input  wire logic [W-1:0] alt_data_in,
    input  wire logic [W-1:0] alt_pp_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_out,
    output logic      [W-1:0] pullup_out,
    output logic      [W-1:0] irq_en_out
);
    logic [W-1:0] pp_ok;
    logic [W-1:0] sw_pp;
    logic [W-1:0] sw_oe;
    logic [W-1:0] alt_oe;

    // Port with true open drain has no pull-up, and drives high only for a push-pull peripheral
    assign pp_ok = TRUE_OD ? '0 : '1;

    // R8 push-pull or open drain
    assign sw_pp = dir_in & opt_in & pp_ok;
    // R9 high side only in push-pull
    assign sw_oe = dir_in & (sw_pp | ~val_in);
    assign alt_oe = alt_pp_in | ~alt_data_in;

    // R13 peripheral overrides standard settings
    assign pin_oe_out = (alt_en_in & alt_oe) | (~alt_en_in & sw_oe);
    // Open drain pulls low only, so data is high only in push-pull
    assign pin_out = (alt_en_in & alt_pp_in & alt_data_in)
                   | (~alt_en_in & sw_pp & val_in);

    // R7 pulled-up input with interrupt on B and C
    // R9 pull-up only in pull-up mode
    assign pullup_out = ~alt_en_in & ~dir_in & opt_in & pp_ok;

    // R12 no interrupt in output mode
    assign irq_en_out = ~alt_en_in & ~dir_in & opt_in;
endmodule : gpb_pin_ctrl

// ==== logic/gpb_pkg.sv ====
package gpb_pkg;

    // Bus geometry
    localparam int GPB_ADDR_W = 12;
    localparam int GPB_IDX_W  = 10;
    localparam int GPB_DATA_W = 32;

    // Pins per port
    localparam int GPB_PA_W = 8;
    localparam int GPB_PB_W = 8;
    localparam int GPB_PC_W = 6;

    // Register indexes; byte address is four times the index
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PC_VAL = 10'h000;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PC_DIR = 10'h001;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PC_OPT = 10'h002;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PB_VAL = 10'h004;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PB_DIR = 10'h005;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PB_OPT = 10'h006;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PA_VAL = 10'h008;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PA_DIR = 10'h009;
    localparam logic [GPB_IDX_W-1:0] GPB_IDX_PA_OPT = 10'h00A;

    // Word alignment bits of the byte address
    localparam logic [1:0] GPB_ALIGN_OK = 2'h0;

    // Reset values
    localparam logic [7:0]            GPB_REG_RST  = 8'h00;
    localparam logic [GPB_DATA_W-1:0] GPB_DATA_RST = 32'h0000_0000;

endpackage : gpb_pkg

// ==== logic/gpb_port_bank.sv ====
// Function
// R1 - bit X of each register serves pin X
// R2 - direction bit 0 input, 1 output
// R3 - value and direction reset to zero
// R4 - input pin reads external pin level
// R5 - output pin drives and reads latch
// R6 - value write always updates the latch
// R7 - option selects floating or interrupt input
// R8 - option selects open drain or push-pull
// R9 - pad pull-up and driver follow mode
// R10 - interrupt input raises external request
// R11 - pins sharing a vector are ANDed
// R12 - output mode disables pin interrupt
// R13 - peripheral function overrides pin settings
// R14 - peripheral input pin stays readable
// R15 - shared peripheral pin kept as input
// R16 - no peripheral on interrupt input
// R17 - analog input uses floating input
// R18 - write value before switching to output
// R19 - option registers reset to zero
// R20 - pin levels pass two flip-flops
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module gpb_port_bank
    import gpb_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    // APB slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [GPB_ADDR_W-1:0] paddr_in,
    input  wire logic [GPB_DATA_W-1:0] pwdata_in,
    output logic      [GPB_DATA_W-1:0] prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // Port A pins
    input  wire logic [GPB_PA_W-1:0]   pa_pin_in,
    output logic      [GPB_PA_W-1:0]   pa_pin_out,
    output logic      [GPB_PA_W-1:0]   pa_pin_oe_out,
    output logic      [GPB_PA_W-1:0]   pa_pullup_out,
    // Port B pins
    input  wire logic [GPB_PB_W-1:0]   pb_pin_in,
    output logic      [GPB_PB_W-1:0]   pb_pin_out,
    output logic      [GPB_PB_W-1:0]   pb_pin_oe_out,
    output logic      [GPB_PB_W-1:0]   pb_pullup_out,
    // Port C pins
    input  wire logic [GPB_PC_W-1:0]   pc_pin_in,
    output logic      [GPB_PC_W-1:0]   pc_pin_out,
    output logic      [GPB_PC_W-1:0]   pc_pin_oe_out,
    output logic      [GPB_PC_W-1:0]   pc_pullup_out,
    // Peripheral alternate functions
    input  wire logic [GPB_PA_W-1:0]   pa_alt_en_in,
    input  wire logic [GPB_PA_W-1:0]   pa_alt_data_in,
    input  wire logic [GPB_PA_W-1:0]   pa_alt_pp_in,
    input  wire logic [GPB_PB_W-1:0]   pb_alt_en_in,
    input  wire logic [GPB_PB_W-1:0]   pb_alt_data_in,
    input  wire logic [GPB_PB_W-1:0]   pb_alt_pp_in,
    input  wire logic [GPB_PC_W-1:0]   pc_alt_en_in,
    input  wire logic [GPB_PC_W-1:0]   pc_alt_data_in,
    input  wire logic [GPB_PC_W-1:0]   pc_alt_pp_in,
    // Pin levels seen by synchronous pins (for peripheral inputs)
    output logic      [GPB_PA_W-1:0]   pa_level_out,
    output logic      [GPB_PB_W-1:0]   pb_level_out,
    output logic      [GPB_PC_W-1:0]   pc_level_out,
    // Combined request levels to the edge/level detectors
    output logic                       ei0_level_out,
    output logic                       ei1_level_out
);
    import gpb_pkg::*;

    // Value latches, directions and options
    logic [GPB_PA_W-1:0] pa_val_r, pa_dir_r, pa_opt_r;
    logic [GPB_PB_W-1:0] pb_val_r, pb_dir_r, pb_opt_r;
    logic [GPB_PC_W-1:0] pc_val_r, pc_dir_r, pc_opt_r;

    logic [GPB_PA_W-1:0] pa_sync, pa_out_c, pa_oe_c, pa_pu_c, pa_irq_c;
    logic [GPB_PB_W-1:0] pb_sync, pb_out_c, pb_oe_c, pb_pu_c, pb_irq_c;
    logic [GPB_PC_W-1:0] pc_sync, pc_out_c, pc_oe_c, pc_pu_c, pc_irq_c;

    logic                 ready_r;
    logic                 acc_first;
    logic                 acc_done;
    logic                 wr_en;
    logic                 hit;
    logic [7:0]           rd_byte;
    logic [GPB_IDX_W-1:0] idx;
    logic [7:0]           wbyte;

    // Per-bit read view: latch when output, pin level when input
    function automatic logic [7:0] rd_view(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        rd_view = (dir & latch) | (~dir & pin);
    endfunction : rd_view

    // R20 pin synchronisers
    gpb_sync #(.W(GPB_PA_W)) u_sync_a (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pa_pin_in),
        .sync_out   (pa_sync)
    );
    gpb_sync #(.W(GPB_PB_W)) u_sync_b (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pb_pin_in),
        .sync_out   (pb_sync)
    );
    gpb_sync #(.W(GPB_PC_W)) u_sync_c (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pc_pin_in),
        .sync_out   (pc_sync)
    );

    // Pad decode; port A is the true open-drain port
    gpb_pin_ctrl #(.W(GPB_PA_W), .TRUE_OD(1'b1)) u_ctrl_a (
        .val_in      (pa_val_r),
        .dir_in      (pa_dir_r),
        .opt_in      (pa_opt_r),
        .alt_en_in   (pa_alt_en_in),
        .alt_data_in (pa_alt_data_in),
        .alt_pp_in   (pa_alt_pp_in),
        .pin_out     (pa_out_c),
        .pin_oe_out  (pa_oe_c),
        .pullup_out  (pa_pu_c),
        .irq_en_out  (pa_irq_c)
    );
    gpb_pin_ctrl #(.W(GPB_PB_W), .TRUE_OD(1'b0)) u_ctrl_b (
        .val_in      (pb_val_r),
        .dir_in      (pb_dir_r),
        .opt_in      (pb_opt_r),
        .alt_en_in   (pb_alt_en_in),
        .alt_data_in (pb_alt_data_in),
        .alt_pp_in   (pb_alt_pp_in),
        .pin_out     (pb_out_c),
        .pin_oe_out  (pb_oe_c),
        .pullup_out  (pb_pu_c),
        .irq_en_out  (pb_irq_c)
    );
    gpb_pin_ctrl #(.W(GPB_PC_W), .TRUE_OD(1'b0)) u_ctrl_c (
        .val_in      (pc_val_r),
        .dir_in      (pc_dir_r),
        .opt_in      (pc_opt_r),
        .alt_en_in   (pc_alt_en_in),
        .alt_data_in (pc_alt_data_in),
        .alt_pp_in   (pc_alt_pp_in),
        .pin_out     (pc_out_c),
        .pin_oe_out  (pc_oe_c),
        .pullup_out  (pc_pu_c),
        .irq_en_out  (pc_irq_c)
    );

    // Bus phase decode; one wait state so read data comes from a flop
    assign idx       = paddr_in[GPB_ADDR_W-1:2];
    assign acc_first = psel_in & penable_in & ~ready_r;
    assign acc_done  = psel_in & penable_in & ready_r;
    assign wr_en     = acc_done & pwrite_in & hit;
    assign wbyte     = pwdata_in[7:0];

    // Register read mux; unmapped or misaligned answers an error
    always_comb
    begin
        hit     = (paddr_in[1:0] == GPB_ALIGN_OK);
        rd_byte = GPB_REG_RST;
        case (idx)
            // R4 input reads pin, R5 output reads latch
            // R14 peripheral input pin stays readable
            GPB_IDX_PA_VAL: rd_byte = rd_view(pa_val_r, pa_dir_r, pa_sync);
            GPB_IDX_PB_VAL: rd_byte = rd_view(pb_val_r, pb_dir_r, pb_sync);
            GPB_IDX_PC_VAL: rd_byte = rd_view({2'h0, pc_val_r},
                                              {2'h0, pc_dir_r},
                                              {2'h0, pc_sync});
            GPB_IDX_PA_DIR: rd_byte = pa_dir_r;
            GPB_IDX_PB_DIR: rd_byte = pb_dir_r;
            GPB_IDX_PC_DIR: rd_byte = {2'h0, pc_dir_r};
            GPB_IDX_PA_OPT: rd_byte = pa_opt_r;
            GPB_IDX_PB_OPT: rd_byte = pb_opt_r;
            GPB_IDX_PC_OPT: rd_byte = {2'h0, pc_opt_r};
            default:        hit = 1'b0;
        endcase
    end

    // Ready rises in the second access cycle, then drops
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ready_r <= 1'b0;
        else
            ready_r <= acc_first;
    end

    // Read data and error are captured on the same edge that raises ready
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prdata_out  <= GPB_DATA_RST;
            pslverr_out <= 1'b0;
        end
        else if (acc_first)
        begin
            // Refused reads return zero, never a register's content
            prdata_out  <= (pwrite_in || !hit) ? GPB_DATA_RST
                                               : {24'h00_0000, rd_byte};
            pslverr_out <= ~hit;
        end
        else if (!psel_in)
        begin
            pslverr_out <= 1'b0;
        end
    end

    assign pready_out = ready_r;

    // R3 value and direction clear at reset
    // R19 option clears at reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pa_val_r <= GPB_REG_RST;
            pa_dir_r <= GPB_REG_RST;
            pa_opt_r <= GPB_REG_RST;
        end
        else if (wr_en)
        begin
            // R6 latch written whatever the direction
            // R1 bit X drives pin X
            if (idx == GPB_IDX_PA_VAL)
                pa_val_r <= wbyte;
            // R2 software sets and clears direction
            if (idx == GPB_IDX_PA_DIR)
                pa_dir_r <= wbyte;
            if (idx == GPB_IDX_PA_OPT)
                pa_opt_r <= wbyte;
        end
    end

    // Port B registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pb_val_r <= GPB_REG_RST;
            pb_dir_r <= GPB_REG_RST;
            pb_opt_r <= GPB_REG_RST;
        end
        else if (wr_en)
        begin
            // R6 latch written whatever the direction
            if (idx == GPB_IDX_PB_VAL)
                pb_val_r <= wbyte;
            if (idx == GPB_IDX_PB_DIR)
                pb_dir_r <= wbyte;
            if (idx == GPB_IDX_PB_OPT)
                pb_opt_r <= wbyte;
        end
    end

    // Port C registers; only six pins, upper bits read zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pc_val_r <= GPB_REG_RST[GPB_PC_W-1:0];
            pc_dir_r <= GPB_REG_RST[GPB_PC_W-1:0];
            pc_opt_r <= GPB_REG_RST[GPB_PC_W-1:0];
        end
        else if (wr_en)
        begin
            // R6 latch written whatever the direction
            if (idx == GPB_IDX_PC_VAL)
                pc_val_r <= wbyte[GPB_PC_W-1:0];
            if (idx == GPB_IDX_PC_DIR)
                pc_dir_r <= wbyte[GPB_PC_W-1:0];
            if (idx == GPB_IDX_PC_OPT)
                pc_opt_r <= wbyte[GPB_PC_W-1:0];
        end
    end

    // Pad controls registered so pins never see decode glitches
    // R9 pad controls follow the mode
    // R13 peripheral override reaches the pad
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pa_pin_out    <= '0;
            pa_pin_oe_out <= '0;
            pa_pullup_out <= '0;
            pb_pin_out    <= '0;
            pb_pin_oe_out <= '0;
            pb_pullup_out <= '0;
            pc_pin_out    <= '0;
            pc_pin_oe_out <= '0;
            pc_pullup_out <= '0;
        end
        else
        begin
            pa_pin_out    <= pa_out_c;
            pa_pin_oe_out <= pa_oe_c;
            pa_pullup_out <= pa_pu_c;
            pb_pin_out    <= pb_out_c;
            pb_pin_oe_out <= pb_oe_c;
            pb_pullup_out <= pb_pu_c;
            pc_pin_out    <= pc_out_c;
            pc_pin_oe_out <= pc_oe_c;
            pc_pullup_out <= pc_pu_c;
        end
    end

    // Synchronised levels for peripheral inputs, one more flop
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pa_level_out <= '0;
            pb_level_out <= '0;
            pc_level_out <= '0;
        end
        else
        begin
            pa_level_out <= pa_sync;
            pb_level_out <= pb_sync;
            pc_level_out <= pc_sync;
        end
    end

    // Disabled pins count as high so they never mask the others;
    // idle level is high, matching a falling-edge detector at rest
    // R10 interrupt inputs feed the request
    // R11 pins of one vector ANDed
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ei0_level_out <= 1'b1;
            ei1_level_out <= 1'b1;
        end
        else
        begin
            ei0_level_out <= &(pa_sync | ~pa_irq_c);
            ei1_level_out <= &(pb_sync | ~pb_irq_c)
                           & &(pc_sync | ~pc_irq_c);
        end
    end

endmodule : gpb_port_bank

// ==== logic/gpb_sync.sv ====
`timescale 1ns/1ps

// Two-flop synchroniser for asynchronous pin levels
module gpb_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : gpb_sync

// ==== test/gpb_chk.sv ====
`timescale 1ns/1ps

// Port-level checks of bus timing and pad state
module gpb_chk
    import gpb_pkg::*;
(
    input wire logic                  sys_clk_in,
    input wire logic                  rst_n_in,
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic [GPB_ADDR_W-1:0] paddr_in,
    input wire logic [GPB_DATA_W-1:0] prdata_out,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    input wire logic [GPB_PA_W-1:0]   pa_pin_in,
    input wire logic [GPB_PA_W-1:0]   pa_pullup_out,
    input wire logic [GPB_PA_W-1:0]   pa_level_out,
    input wire logic [GPB_PB_W-1:0]   pb_pin_in,
    input wire logic [GPB_PB_W-1:0]   pb_pin_out,
    input wire logic [GPB_PB_W-1:0]   pb_pin_oe_out,
    input wire logic [GPB_PB_W-1:0]   pb_pullup_out,
    input wire logic [GPB_PB_W-1:0]   pb_alt_en_in,
    input wire logic [GPB_PB_W-1:0]   pb_alt_data_in,
    input wire logic [GPB_PB_W-1:0]   pb_alt_pp_in,
    input wire logic [GPB_PC_W-1:0]   pc_pin_in,
    input wire logic                  ei0_level_out,
    input wire logic                  ei1_level_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Setup cycle, then one wait state, then the answer
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_answer;
        !pready_out ##1 pready_out;
    endsequence

    a_ready_wait: assert property (s_setup |=> s_answer)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_err_misalign: assert property (pready_out
        && paddr_in[1:0] != GPB_ALIGN_OK |-> pslverr_out)
        else $error("misaligned access not refused");
    a_rdata_upper: assert property (pready_out |->
        prdata_out[31:8] == 24'h0) else $error("read upper bits set");
    a_pa_no_pull: assert property (pa_pullup_out == 8'h00)
        else $error("port A pull-up enabled");
    a_pull_drive: assert property ((pb_pullup_out & pb_pin_oe_out)
        == 8'h00) else $error("pull-up while driving");
    a_alt_push: assert property ($past(rst_n_in) |->
        ((pb_pin_oe_out | ~$past(pb_alt_en_in & pb_alt_pp_in)) == 8'hFF)
        && (((pb_pin_out ^ $past(pb_alt_data_in))
        & $past(pb_alt_en_in & pb_alt_pp_in)) == 8'h00))
        else $error("peripheral push-pull not on pad");
    a_level_sync: assert property ($stable(pa_pin_in)[*4] |->
        pa_level_out == pa_pin_in) else $error("pin level late");
    a_ei0_and: assert property ($stable(pa_pin_in)[*4]
        ##0 (&pa_pin_in) |-> ei0_level_out) else $error("ei0 low");
    a_ei1_and: assert property ($stable({pb_pin_in, pc_pin_in})[*4]
        ##0 (&{pb_pin_in, pc_pin_in}) |-> ei1_level_out)
        else $error("ei1 low");
endmodule : gpb_chk

bind gpb_port_bank gpb_chk chk_u (.*);

// ==== test/gpb_pin_env.sv ====
`timescale 1ns/1ps

// Board model of one port: pads, outside driver, pull-ups
module gpb_pin_env #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_in,
    input  wire logic [W-1:0] drv_in,
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] pull_in,
    input  wire logic         ext_en_in,
    input  wire logic [W-1:0] ext_val_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] noise_r = '0;

    // Undriven pins change every cycle so stale values never pass
    always_ff @(posedge sys_clk_in)
    begin
        noise_r <= ~noise_r;
    end

    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (oe_in[i] === 1'b1) pin_out[i] = drv_in[i];
            else if (ext_en_in) pin_out[i] = ext_val_in[i];
            else if (pull_in[i] === 1'b1) pin_out[i] = 1'b1;
            else pin_out[i] = noise_r[i];
        end
    end
endmodule : gpb_pin_env

// ==== test/gpb_port_bank_tb.sv ====
`timescale 1ns/1ps

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end

module gpb_port_bank_tb;
    import gpb_pkg::*;
    localparam logic [9:0] BIDX [3] = '{GPB_IDX_PA_VAL, GPB_IDX_PB_VAL,
                                        GPB_IDX_PC_VAL};
    localparam logic [7:0] MSK [3] = '{8'hFF, 8'hFF, 8'h3F};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  alt_en [3] = '{default: 8'h00};
    logic [7:0]  alt_dat [3] = '{default: 8'h00};
    logic [7:0]  alt_pp [3] = '{default: 8'h00};
    logic [7:0]  xval [3] = '{default: 8'hFF};
    wire  [7:0]  pin_o [3];
    wire  [7:0]  oe [3];
    wire  [7:0]  pu [3];
    wire  [7:0]  lvl [3];
    wire  [7:0]  pin_i [3];
    wire         ei0;
    wire         ei1;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [7:0]  m;

    gpb_port_bank dut_u (
        .sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr),
        .pa_pin_in(pin_i[0]), .pa_pin_out(pin_o[0]),
        .pa_pin_oe_out(oe[0]), .pa_pullup_out(pu[0]),
        .pb_pin_in(pin_i[1]), .pb_pin_out(pin_o[1]),
        .pb_pin_oe_out(oe[1]), .pb_pullup_out(pu[1]),
        .pc_pin_in(pin_i[2][5:0]), .pc_pin_out(pin_o[2][5:0]),
        .pc_pin_oe_out(oe[2][5:0]), .pc_pullup_out(pu[2][5:0]),
        .pa_alt_en_in(alt_en[0]), .pa_alt_data_in(alt_dat[0]),
        .pa_alt_pp_in(alt_pp[0]), .pb_alt_en_in(alt_en[1]),
        .pb_alt_data_in(alt_dat[1]), .pb_alt_pp_in(alt_pp[1]),
        .pc_alt_en_in(alt_en[2][5:0]), .pc_alt_data_in(alt_dat[2][5:0]),
        .pc_alt_pp_in(alt_pp[2][5:0]), .pa_level_out(lvl[0]),
        .pb_level_out(lvl[1]), .pc_level_out(lvl[2][5:0]),
        .ei0_level_out(ei0), .ei1_level_out(ei1)
    );

    // One board model per port
    for (genvar g = 0; g < 3; g++)
    begin : g_env
        gpb_pin_env #(.W(8)) env_u (
            .sys_clk_in(clk), .drv_in(pin_o[g]), .oe_in(oe[g]),
            .pull_in(pu[g]), .ext_en_in(1'b1), .ext_val_in(xval[g]),
            .pin_out(pin_i[g])
        );
    end

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_fail++;
            conclude();
        end
    end

    function automatic logic [11:0] ad(input int p, input int r);
        ad = {BIDX[p] + 10'(r), 2'h0};
    endfunction : ad

    // One APB transfer; only the hang guard ends the wait for pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, x)
        `CHK(e, xe)
    endtask : rd

    // Pad outputs settle one edge after the register
    task automatic pad(input int p, input logic [7:0] xo,
                       input logic [7:0] xp, input logic [7:0] xu);
        repeat (2) @(posedge clk);
        `CHK(oe[p] & MSK[p], xo & MSK[p])
        `CHK(pin_o[p] & xo & MSK[p], xp & xo & MSK[p])
        `CHK(pu[p] & MSK[p], xu & MSK[p])
    endtask : pad

    task automatic pins(input int p, input logic [7:0] v);
        xval[p] <= v;
        repeat (5) @(posedge clk);
    endtask : pins

    task conclude;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            m = MSK[p];
            rd(ad(p, 1), 32'h0, 1'b0);
            rd(ad(p, 2), 32'h0, 1'b0);
            wr(ad(p, 1), 32'hFF);
            rd(ad(p, 0), 32'h0, 1'b0);
            wr(ad(p, 0), 32'hA5);
            wr(ad(p, 1), 32'h00);
            pins(p, 8'h5A);
            rd(ad(p, 0), {24'h0, 8'h5A & m}, 1'b0);
            `CHK(lvl[p] & m, 8'h5A & m)
            wr(ad(p, 1), 32'hFF);
            rd(ad(p, 0), {24'h0, 8'hA5 & m}, 1'b0);
            pad(p, 8'h5A, 8'h00, 8'h00);
            wr(ad(p, 2), 32'hFF);
            pad(p, p ? 8'hFF : 8'h5A, p ? 8'hA5 : 8'h00, 8'h00);
            wr(ad(p, 1), 32'h00);
            pad(p, 8'h00, 8'h00, p ? 8'hFF : 8'h00);
            wr(ad(p, 2), 32'h00);
            pad(p, 8'h00, 8'h00, 8'h00);
        end
        // Shared vector of port A: enable, mask, output mode
        wr(ad(0, 2), 32'h01);
        pins(0, 8'hFF);
        `CHK(ei0, 1'b1)
        pins(0, 8'hFE);
        `CHK(ei0, 1'b0)
        pins(0, 8'h01);
        `CHK(ei0, 1'b1)
        wr(ad(0, 2), 32'hFF);
        pins(0, 8'h01);
        `CHK(ei0, 1'b0)
        wr(ad(0, 1), 32'hFF);
        pins(0, 8'h01);
        `CHK(ei0, 1'b1)
        wr(ad(0, 1), 32'h00);
        wr(ad(0, 2), 32'h00);
        // Ports B and C share the second vector
        wr(ad(1, 2), 32'hFF);
        wr(ad(2, 2), 32'h3F);
        pins(1, 8'hFF);
        pins(2, 8'h3F);
        `CHK(ei1, 1'b1)
        pins(2, 8'h3E);
        `CHK(ei1, 1'b0)
        wr(ad(1, 2), 32'h00);
        wr(ad(2, 2), 32'h00);
        alt_en[1] <= 8'hFF;
        alt_pp[1] <= 8'hFF;
        alt_dat[1] <= 8'h3C;
        pad(1, 8'hFF, 8'h3C, 8'h00);
        pins(1, 8'hFF);
        rd(ad(1, 0), 32'h3C, 1'b0);
        alt_pp[1] <= 8'h00;
        pad(1, 8'hC3, 8'h00, 8'h00);
        alt_en[1] <= 8'h00;
        // Refused addresses leave registers alone
        rd(12'h00C, 32'h0, 1'b1);
        rd(12'h021, 32'h0, 1'b1);
        wr(12'h026, 32'hFF);
        rd(ad(0, 1), 32'h0, 1'b0);
        wr(ad(1, 1), 32'h81);
        rd(ad(1, 1), 32'h81, 1'b0);
        // Second reset in mid-run
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(ad(1, 1), 32'h0, 1'b0);
        conclude();
    end
endmodule : gpb_port_bank_tb
